/* File: hw/etec_pkg.sv */
// Constants, offsets and field layout of the eight-bit timer/event counter
package etec_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_COUNT = 8'h00;
	localparam logic [7:0] OFS_COMPARE = 8'h04;
	localparam logic [7:0] OFS_CLKSEL = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0c;
	localparam logic [7:0] OFS_PORT = 8'h10;

	// ----------------------------------------------------------------
	// Mode control field positions
	// ----------------------------------------------------------------
	localparam int MODE_RUN = 7;
	localparam int MODE_PWM = 6;
	localparam int MODE_PRESET_HIGH = 3;
	localparam int MODE_PRESET_LOW = 2;
	localparam int MODE_INV_POL = 1;
	localparam int MODE_OUT_EN = 0;

	// ----------------------------------------------------------------
	// Port register field positions
	// ----------------------------------------------------------------
	localparam int PORT_LATCH = 0;
	localparam int PORT_DIR = 1;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_COMPARE = 8'h00;
	localparam logic [2:0] RST_CLKSEL = 3'h0;
	localparam logic RST_DIR = 1'b1;
	localparam logic RST_LATCH = 1'b0;

	// ----------------------------------------------------------------
	// Counter landmarks
	// ----------------------------------------------------------------
	localparam logic [7:0] CNT_TOP = 8'hff;
	localparam logic [7:0] CNT_PRE_TOP = 8'hfe;
	localparam logic [7:0] CNT_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// Count clock select codes and prescaler
	// ----------------------------------------------------------------
	localparam logic [2:0] CKS_EV_FALL = 3'h0;
	localparam logic [2:0] CKS_EV_RISE = 3'h1;
	localparam logic [2:0] CKS_DIV2 = 3'h2;
	localparam logic [2:0] CKS_DIV4 = 3'h3;
	localparam logic [2:0] CKS_DIV16 = 3'h4;
	localparam logic [2:0] CKS_DIV64 = 3'h5;
	localparam logic [2:0] CKS_DIV256 = 3'h6;
	localparam int PRESCALE_BITS = 13;

	// AHB transfer type
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : etec_pkg

/* File: hw/etec_count_clk.sv */
// Count clock enable: prescaler taps and event pin edge detect
`timescale 1ns/1ps
`default_nettype none

module etec_count_clk (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Selection and pin
	input wire logic [2:0] clk_sel,
	input wire logic event_in,
	// Count clock enable
	output logic count_en
);

	// ----------------------------------------------------------------
	// Free-running prescaler
	// ----------------------------------------------------------------
	logic [etec_pkg::PRESCALE_BITS-1:0] div_r;
	logic event_d_r;
	logic tap;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_r <= '0;
		else
			div_r <= div_r + etec_pkg::PRESCALE_BITS'(1);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			event_d_r <= 1'b0;
		else
			event_d_r <= event_in;
	end

	// ----------------------------------------------------------------
	// Tap selection
	// ----------------------------------------------------------------
	always_comb begin
		if (clk_sel == etec_pkg::CKS_EV_FALL)
			tap = event_d_r & ~event_in;
		else if (clk_sel == etec_pkg::CKS_EV_RISE)
			tap = ~event_d_r & event_in;
		else if (clk_sel == etec_pkg::CKS_DIV2)
			tap = &div_r[0:0];
		else if (clk_sel == etec_pkg::CKS_DIV4)
			tap = &div_r[1:0];
		else if (clk_sel == etec_pkg::CKS_DIV16)
			tap = &div_r[3:0];
		else if (clk_sel == etec_pkg::CKS_DIV64)
			tap = &div_r[5:0];
		else if (clk_sel == etec_pkg::CKS_DIV256)
			tap = &div_r[7:0];
		else
			tap = &div_r;
	end

	assign count_en = tap;

endmodule : etec_count_clk
`default_nettype wire

/* File: hw/etec_out_stage.sv */
// Timer output level and shared pin driver
`timescale 1ns/1ps
`default_nettype none

module etec_out_stage (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Timer state
	input wire logic pwm_mode,
	input wire logic polarity,
	input wire logic out_en,
	input wire logic out_ff,
	input wire logic pwm_active,
	// Port controls
	input wire logic pin_dir,
	input wire logic pin_latch,
	// Pin
	output logic pin_out,
	output logic pin_oe,
	output logic timer_out
);

	logic level;

	// ----------------------------------------------------------------
	// Output level
	// ----------------------------------------------------------------
	always_comb begin
		if (!out_en)
			level = 1'b0;
		else if (pwm_mode)
			level = pwm_active ^ polarity;
		else
			level = out_ff;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			timer_out <= 1'b0;
		else
			timer_out <= level;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pin_out <= 1'b0;
		else
			pin_out <= level | pin_latch;
	end

	assign pin_oe = ~pin_dir;

endmodule : etec_out_stage
`default_nettype wire

/* File: hw/etec_top.sv */
// Eight-bit timer/event counter with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module etec_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Timer pin
	input wire logic external_event_pin,
	output logic timer_output_pin,
	output logic timer_output_pin_oe,
	// Events and level
	output logic match_interrupt,
	output logic timer_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [7:0] event_count_register_r;
	logic [7:0] compare_value_register_r;
	logic [7:0] cmp_active_r;
	logic cmp_pending_r;
	logic cmp_armed_r;
	logic [2:0] count_clock_select_r;
	logic count_run_bit_r;
	logic pwm_mode_bit_r;
	logic inversion_or_polarity_bit_r;
	logic output_enable_bit_r;
	logic out_ff_r;
	logic pwm_active_r;
	logic pin_direction_bit_a_r;
	logic pin_output_latch_a_r;
	logic match_interrupt_r;
	logic count_en;
	logic tick;
	logic match;
	logic overflow;
	logic addr_phase;
	logic wr_compare;
	logic wr_mode;
	logic [7:0] wd;
	logic [7:0] cmp_next;
	logic [31:0] rd_nxt;

	// Word select for a register offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel & hready & (htrans == etec_pkg::HTRANS_NONSEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else if (hready) begin
			wr_pend_r <= addr_phase & hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	assign wd = hwdata[7:0];
	assign wr_compare = wr_pend_r & hit(wr_addr_r, etec_pkg::OFS_COMPARE);
	assign wr_mode = wr_pend_r & hit(wr_addr_r, etec_pkg::OFS_MODE);

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (hit(haddr[7:0], etec_pkg::OFS_COUNT))
			rd_nxt[7:0] = event_count_register_r;
		else if (hit(haddr[7:0], etec_pkg::OFS_COMPARE))
			rd_nxt[7:0] = compare_value_register_r;
		else if (hit(haddr[7:0], etec_pkg::OFS_CLKSEL))
			rd_nxt[2:0] = count_clock_select_r;
		else if (hit(haddr[7:0], etec_pkg::OFS_MODE))
			rd_nxt[7:0] = {count_run_bit_r, pwm_mode_bit_r, 4'h0,
				inversion_or_polarity_bit_r, output_enable_bit_r};
		else if (hit(haddr[7:0], etec_pkg::OFS_PORT))
			rd_nxt[1:0] = {pin_direction_bit_a_r, pin_output_latch_a_r};
		else
			rd_nxt = 32'h0000_0000;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (addr_phase && !hwrite)
			hrdata <= rd_nxt;
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			count_clock_select_r <= etec_pkg::RST_CLKSEL;
		else if (wr_pend_r && hit(wr_addr_r, etec_pkg::OFS_CLKSEL))
			count_clock_select_r <= wd[2:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_run_bit_r <= 1'b0;
			pwm_mode_bit_r <= 1'b0;
			inversion_or_polarity_bit_r <= 1'b0;
			output_enable_bit_r <= 1'b0;
		end else if (wr_mode) begin
			count_run_bit_r <= wd[etec_pkg::MODE_RUN];
			pwm_mode_bit_r <= wd[etec_pkg::MODE_PWM];
			inversion_or_polarity_bit_r <= wd[etec_pkg::MODE_INV_POL];
			output_enable_bit_r <= wd[etec_pkg::MODE_OUT_EN];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_direction_bit_a_r <= etec_pkg::RST_DIR;
			pin_output_latch_a_r <= etec_pkg::RST_LATCH;
		end else if (wr_pend_r && hit(wr_addr_r, etec_pkg::OFS_PORT)) begin
			pin_direction_bit_a_r <= wd[etec_pkg::PORT_DIR];
			pin_output_latch_a_r <= wd[etec_pkg::PORT_LATCH];
		end
	end

	// ----------------------------------------------------------------
	// Count clock
	// ----------------------------------------------------------------
	etec_count_clk i_etec_count_clk (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_sel(count_clock_select_r),
		.event_in(external_event_pin),
		.count_en(count_en)
	);

	// Prescaler free-runs, so the first tick after start may come early
	assign tick = count_en & count_run_bit_r;
	assign match = tick & ~pwm_mode_bit_r
		& (event_count_register_r == cmp_active_r);
	assign overflow = tick & pwm_mode_bit_r
		& (event_count_register_r == etec_pkg::CNT_TOP);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			event_count_register_r <= etec_pkg::RST_COUNT;
		else if (!count_run_bit_r)
			event_count_register_r <= etec_pkg::CNT_ZERO;
		else if (match)
			event_count_register_r <= etec_pkg::CNT_ZERO;
		else if (tick)
			event_count_register_r <= event_count_register_r + 8'h01;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			match_interrupt_r <= 1'b0;
		else
			match_interrupt_r <= match;
	end

	assign match_interrupt = match_interrupt_r;

	// ----------------------------------------------------------------
	// Compare register with PWM buffering
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			compare_value_register_r <= etec_pkg::RST_COMPARE;
		else if (wr_compare)
			compare_value_register_r <= wd;
	end

	assign cmp_next = cmp_armed_r ? compare_value_register_r : cmp_active_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cmp_active_r <= etec_pkg::RST_COMPARE;
		else if (wr_compare && !pwm_mode_bit_r)
			cmp_active_r <= wd;
		else if (!pwm_mode_bit_r)
			cmp_active_r <= compare_value_register_r;
		else if (overflow)
			cmp_active_r <= cmp_next;
	end

	// Write seen before the tick into FFH arms the next overflow
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cmp_pending_r <= 1'b0;
		else if (wr_compare && pwm_mode_bit_r)
			cmp_pending_r <= 1'b1;
		else if (overflow && cmp_armed_r)
			cmp_pending_r <= 1'b0;
		else if (!pwm_mode_bit_r)
			cmp_pending_r <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cmp_armed_r <= 1'b0;
		else if (!pwm_mode_bit_r || overflow)
			cmp_armed_r <= 1'b0;
		else if (tick && event_count_register_r == etec_pkg::CNT_PRE_TOP)
			cmp_armed_r <= cmp_pending_r;
	end

	// ----------------------------------------------------------------
	// Output flip-flop and PWM state
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			out_ff_r <= 1'b0;
		else if (wr_mode && !wd[etec_pkg::MODE_PWM]
			&& (wd[etec_pkg::MODE_PRESET_HIGH]
			^ wd[etec_pkg::MODE_PRESET_LOW]))
			out_ff_r <= wd[etec_pkg::MODE_PRESET_HIGH];
		else if (match && inversion_or_polarity_bit_r)
			out_ff_r <= ~out_ff_r;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pwm_active_r <= 1'b0;
		else if (!count_run_bit_r || !pwm_mode_bit_r)
			pwm_active_r <= 1'b0;
		else if (overflow)
			pwm_active_r <= (cmp_next != etec_pkg::CNT_ZERO);
		else if (tick && (event_count_register_r + 8'h01) == cmp_active_r)
			pwm_active_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	etec_out_stage i_etec_out_stage (
		.hclk(hclk),
		.hresetn(hresetn),
		.pwm_mode(pwm_mode_bit_r),
		.polarity(inversion_or_polarity_bit_r),
		.out_en(output_enable_bit_r),
		.out_ff(out_ff_r),
		.pwm_active(pwm_active_r),
		.pin_dir(pin_direction_bit_a_r),
		.pin_latch(pin_output_latch_a_r),
		.pin_out(timer_output_pin),
		.pin_oe(timer_output_pin_oe),
		.timer_out(timer_out)
	);

endmodule : etec_top
`default_nettype wire

/* File: sim/etec_chk.sv */
// Port checker for the timer/event counter
`timescale 1ns/1ps
`default_nettype none

module etec_chk (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Timer
	input wire logic timer_output_pin_oe,
	input wire logic match_interrupt,
	input wire logic timer_out
);
	// ----
	// Register shadow
	// ----
	logic [7:0] sh_r [0:4];
	logic wph_r, ok_r, to_r;
	logic [5:0] wa_r;
	logic [15:0] gap_r;
	wire logic run_s = sh_r[3][7];
	wire logic pwm_s = sh_r[3][6];
	wire logic pol_s = sh_r[3][1];
	wire logic oe_s = sh_r[3][0];
	wire logic div2_s = sh_r[2][2:0] == etec_pkg::CKS_DIV2;
	wire logic rise_w = timer_out & ~to_r;
	wire logic fall_w = ~timer_out & to_r;
	wire logic ev_w = pwm_s ? rise_w : match_interrupt;
	wire logic pok_w = ok_r & pwm_s & ~pol_s & oe_s & div2_s;
	wire logic [15:0] per_w = {7'h0, sh_r[1], 1'b0} + 16'h2;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph_r <= 1'b0;
			wa_r <= 6'h0;
			sh_r <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
		end else begin
			wph_r <= hsel & hready & hwrite & (htrans == etec_pkg::HTRANS_NONSEQ);
			wa_r <= haddr[7:2];
			if (wph_r && wa_r < 6'h5)
				sh_r[wa_r[2:0]] <= hwdata[7:0];
		end
	end

	// Event spacing, restarted by any register write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			to_r <= 1'b0;
			ok_r <= 1'b0;
			gap_r <= 16'h0;
		end else begin
			to_r <= timer_out;
			ok_r <= !wph_r && (ev_w || ok_r);
			gap_r <= ev_w ? 16'h1 : gap_r + 16'h1;
		end
	end

	// ----
	// Properties
	// ----
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_pwm_idle;
		pwm_s && oe_s && !run_s && $stable(pol_s);
	endsequence
	property p_pwm_idle;
		s_pwm_idle [*3] |-> timer_out == pol_s;
	endproperty
	property p_oe;
		timer_output_pin_oe == !sh_r[4][1];
	endproperty
	property p_out_low;
		!oe_s && !$past(oe_s) |-> !timer_out;
	endproperty
	property p_irq_run;
		match_interrupt |-> $past(run_s) || $past(run_s, 2);
	endproperty
	property p_gap;
		match_interrupt && ok_r && !pwm_s && div2_s |-> gap_r == per_w;
	endproperty
	property p_sq;
		ok_r && !pwm_s && oe_s && sh_r[3][1] && run_s
			|-> (timer_out != $past(timer_out)) == $past(match_interrupt);
	endproperty
	property p_pwm_per;
		rise_w && pok_w |-> gap_r == 16'h0200;
	endproperty
	property p_pwm_width;
		fall_w && pok_w |-> gap_r == {7'h0, sh_r[1], 1'b0};
	endproperty

	a_pwm_idle: assert property (p_pwm_idle) else $error("pwm not idle");
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	a_out_low: assert property (p_out_low) else $error("output not low");
	a_irq_run: assert property (p_irq_run) else $error("match when stopped");
	a_gap: assert property (p_gap) else $error("match interval wrong");
	a_sq: assert property (p_sq) else $error("toggle without match");
	a_pwm_per: assert property (p_pwm_per) else $error("pwm period wrong");
	a_pwm_width: assert property (p_pwm_width) else $error("pwm width wrong");
endmodule // etec_chk

bind etec_top etec_chk i_chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.timer_output_pin_oe, .match_interrupt, .timer_out
);

`default_nettype wire

/* File: sim/etec_partner.sv */
// Event source and load on the shared timer pin
`timescale 1ns/1ps
`default_nettype none

module etec_partner (
	// Clock
	input wire logic hclk,
	// Pulse request
	input wire logic start,
	input wire logic [7:0] n_pulses,
	input wire logic [3:0] hold,
	output logic busy,
	// Pin
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_level
);
	logic src_r = 1'b0;
	logic [8:0] left_r = 9'h000;
	logic [3:0] wait_r = 4'h0;

	assign busy = left_r != 9'h000;

	// Wire level: the device wins while its buffer is on
	assign pin_level = pin_oe ? pin_out : src_r;

	// Each level held hold plus one cycles
	always @(posedge hclk) begin
		if (start && !busy) begin
			left_r <= {n_pulses, 1'b0};
			wait_r <= hold;
		end else if (busy && wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
		end else if (busy) begin
			src_r <= ~src_r;
			wait_r <= hold;
			left_r <= left_r - 9'h001;
		end
	end
endmodule // etec_partner

`default_nettype wire

/* File: sim/etec_bench.sv */
// Self-checking bench for the timer/event counter
`timescale 1ns/1ps
`default_nettype none

module etec_bench;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, go = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] n_p = 8'h00;
	logic [3:0] hold_p = 4'h0;
	logic hready, hreadyout, hresp, timer_output_pin, timer_output_pin_oe;
	logic match_interrupt, timer_out, busy, pin_w;
	logic [31:0] sel_t [7] = '{32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h2, 32'h2};
	logic [31:0] cmp_t [7] = '{32'h3, 32'h3, 32'h1, 32'h0, 32'h0, 32'h0, 32'hff};
	int gap_t [7] = '{8, 16, 32, 64, 256, 2, 512};
	int n_errors = 0, checks_done = 0, cyc = 0;

	assign hready = hreadyout;
	always #2 hclk = ~hclk;

	etec_top i_etec_top (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .external_event_pin(pin_w),
		.timer_output_pin, .timer_output_pin_oe, .match_interrupt, .timer_out
	);
	etec_partner i_partner (
		.hclk, .start(go), .n_pulses(n_p), .hold(hold_p), .busy,
		.pin_out(timer_output_pin), .pin_oe(timer_output_pin_oe),
		.pin_level(pin_w)
	);

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= etec_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		if (!w)
			chk(hrdata, d);
	endtask

	task automatic lvl(input logic e);
		repeat (6) @(negedge hclk);
		chk({31'h0, timer_out}, {31'h0, e});
		chk({31'h0, timer_output_pin}, {31'h0, e});
	endtask

	function automatic logic ev(input int k, input logic p);
		case (k)
			0: return match_interrupt;
			1: return timer_out & ~p;
			2: return ~timer_out & p;
			default: return timer_out ^ p;
		endcase
	endfunction

	// Cycles from an event of kind ks to the next event of kind ke, which may be the same kind
	task automatic meas(input int ks, input int ke, input int exp);
		int n;
		logic p, hit;
		n = 0;
		@(negedge hclk);
		p = timer_out;
		do begin
			@(negedge hclk);
			hit = ev(ks, p);
			p = timer_out;
		end while (!hit);
		do begin
			@(negedge hclk);
			n++;
			hit = ev(ke, p);
			p = timer_out;
		end while (!hit);
		chk(n, exp);
	endtask

	task automatic pulses(input logic [7:0] n, input logic [3:0] h);
		@(posedge hclk);
		n_p <= n;
		hold_p <= h;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		do @(negedge hclk); while (busy);
		repeat (4) @(negedge hclk);
	endtask

	task automatic test_done;
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			test_done();
		end
	end

	// ----
	// Sequence
	// ----
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			bus(0, 32'(4 * i), (i == 4) ? 32'h2 : 32'h0);
		bus(1, 32'h14, 32'h5a);
		bus(0, 32'h14, 32'h0);
		bus(1, 32'h8, 32'h7);
		bus(0, 32'h8, 32'h7);
		bus(1, 32'hc, 32'h0b);
		bus(0, 32'hc, 32'h03);
		lvl(1'b1);
		bus(1, 32'hc, 32'h08);
		lvl(1'b0);
		bus(1, 32'hc, 32'h01);
		lvl(1'b1);
		bus(1, 32'hc, 32'h07);
		lvl(1'b0);
		bus(1, 32'h8, 32'h1);
		bus(1, 32'h4, 32'hff);
		bus(1, 32'hc, 32'h80);
		pulses(8'h05, 4'h0);
		bus(0, 32'h0, 32'h5);
		bus(1, 32'hc, 32'h0);
		bus(0, 32'h0, 32'h0);
		bus(1, 32'h8, 32'h0);
		bus(1, 32'h4, 32'h2);
		bus(1, 32'hc, 32'h80);
		pulses(8'h04, 4'h5);
		bus(0, 32'h0, 32'h1);
		bus(1, 32'hc, 32'h0);
		foreach (sel_t[i]) begin
			bus(1, 32'h8, sel_t[i]);
			bus(1, 32'h4, cmp_t[i]);
			bus(1, 32'hc, 32'h80);
			meas(0, 0, gap_t[i]);
			bus(1, 32'hc, 32'h0);
		end
		bus(0, 32'h0, 32'h0);
		bus(1, 32'h8, 32'h3);
		bus(1, 32'h4, 32'h1);
		bus(1, 32'hc, 32'h87);
		meas(3, 3, 8);
		bus(1, 32'hc, 32'h0);
		bus(1, 32'h10, 32'h0);
		@(negedge hclk);
		chk({31'h0, timer_output_pin_oe}, 32'h1);
		chk({31'h0, hresp}, 32'h0);
		bus(1, 32'h8, 32'h2);
		bus(1, 32'h4, 32'h40);
		bus(1, 32'hc, 32'h43);
		lvl(1'b1);
		bus(1, 32'hc, 32'hc3);
		meas(2, 1, 128);
		bus(1, 32'hc, 32'h43);
		lvl(1'b1);
		bus(1, 32'hc, 32'h41);
		lvl(1'b0);
		bus(1, 32'hc, 32'hc1);
		meas(1, 2, 128);
		meas(1, 1, 512);
		bus(1, 32'h4, 32'h4);
		bus(0, 32'h4, 32'h4);
		lvl(1'b1);
		meas(1, 2, 8);
		bus(1, 32'hc, 32'h41);
		lvl(1'b0);
		test_done();
	end
endmodule // etec_bench

`default_nettype wire
